/* File: cp_control_register.sv */
// Content-protection transmitter control register bank on APB
`timescale 1ns/1ps
module cp_control_register
  import cp_ctl_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Authentication engine
  input wire auth_sts_t auth_sts,
  output auth_cmd_t auth_cmd,
  // Video datapath
  output video_sel_t video_sel
);
  logic wr_en;
  logic rd_en;
  logic hit_ctl;
  logic hit_cfg;
  logic hit_sts;
  logic wr_ctl;
  logic [7:0] wb;
  logic key_rdy_d_r;
  logic key_rdy_rise;

  logic auth_en_r, auth_en_nxt;
  logic enc_req_r, enc_req_nxt;
  logic key_ok_r, key_ok_nxt;
  logic list_ok_r, list_ok_nxt;
  logic enc_off_r, enc_off_nxt;
  logic rst_r, rst_nxt;
  logic dis_r, dis_nxt;
  logic [1:0] mode_r, mode_nxt;
  auth_cmd_t cmd_r, cmd_nxt;
  video_sel_t vsel_r, vsel_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ready_r, ready_nxt;
  logic err_r, err_nxt;
  logic enc_req_rd;

  assign wr_en = psel & penable & pwrite & ~ready_r;
  assign rd_en = psel & penable & ~pwrite & ~ready_r;
  assign hit_ctl = (paddr == CP_CONTROL_ADDR);
  assign hit_cfg = (paddr == CP_CONFIG_ADDR);
  assign hit_sts = (paddr == CP_STATUS_ADDR);
  assign wr_ctl = wr_en & hit_ctl & pstrb[0];
  assign wb = pwdata[7:0];
  assign key_rdy_rise = auth_sts.receiver_key_ready & ~key_rdy_d_r;
  assign enc_req_rd = (mode_r == MODE_ALWAYS) ? 1'b1 : enc_req_r;

  // Control bits and engine commands
  always_comb begin
    auth_en_nxt = auth_en_r;
    enc_req_nxt = enc_req_r;
    key_ok_nxt = key_ok_r;
    list_ok_nxt = 1'b0;
    enc_off_nxt = 1'b0;
    rst_nxt = 1'b0;
    dis_nxt = 1'b0;
    mode_nxt = mode_r;
    cmd_nxt = '0;
    if (wr_en && hit_cfg && pstrb[0]) begin
      mode_nxt = pwdata[1:0];
    end
    if (wr_ctl) begin
      if (mode_r != MODE_ALWAYS) begin
        enc_req_nxt = wb[BIT_ENC_REQ];
      end
      if (wb[BIT_KEY_OK]) begin
        key_ok_nxt = 1'b1;
        cmd_nxt.key_approved = 1'b1;
      end
      if (wb[BIT_LIST_OK]) begin
        list_ok_nxt = 1'b1;
        cmd_nxt.list_approved = 1'b1;
      end
      enc_off_nxt = wb[BIT_ENC_OFF];
      if (wb[BIT_ENC_OFF]) begin
        enc_req_nxt = 1'b0;
      end
      rst_nxt = wb[BIT_ENGINE_RST];
      dis_nxt = wb[BIT_AUTH_DIS];
      if (wb[BIT_ENGINE_RST]) begin
        auth_en_nxt = 1'b0;
        cmd_nxt.engine_reset = 1'b1;
      end else if (wb[BIT_AUTH_DIS]) begin
        auth_en_nxt = 1'b0;
        cmd_nxt.auth_stop = 1'b1;
      end else if (wb[BIT_AUTH_EN]) begin
        auth_en_nxt = 1'b1;
        cmd_nxt.auth_start = ~auth_en_r;
        cmd_nxt.auth_restart = auth_en_r;
      end
    end
    if (key_rdy_rise) begin
      key_ok_nxt = 1'b0;
    end
  end

  // Video selection
  cp_video_sel u_sel (
    .enc_req(enc_req_rd),
    .enc_off(enc_off_r),
    .enc_mode(mode_r),
    .inband_encrypt(auth_sts.inband_encrypt),
    .authenticated(auth_sts.authenticated),
    .sel(vsel_nxt)
  );

  // APB answer, one wait state
  always_comb begin
    ready_nxt = (psel & penable & ~ready_r);
    err_nxt = 1'b0;
    rdata_nxt = 32'h0000_0000;
    if ((wr_en || rd_en) && !(hit_ctl || hit_cfg || hit_sts)) begin
      err_nxt = 1'b1;
    end
    if (rd_en && hit_ctl) begin
      rdata_nxt[BIT_ENGINE_RST] = rst_r;
      rdata_nxt[BIT_LIST_OK] = list_ok_r;
      rdata_nxt[BIT_KEY_OK] = key_ok_r;
      rdata_nxt[BIT_ENC_OFF] = enc_off_r;
      rdata_nxt[BIT_ENC_REQ] = enc_req_rd;
      rdata_nxt[BIT_AUTH_DIS] = dis_r;
      rdata_nxt[BIT_AUTH_EN] = auth_en_r;
    end else if (rd_en && hit_cfg) begin
      rdata_nxt[1:0] = mode_r;
    end else if (rd_en && hit_sts) begin
      rdata_nxt[4:0] = auth_sts;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auth_en_r <= CP_CONTROL_RESET[BIT_AUTH_EN];
      enc_req_r <= CP_CONTROL_RESET[BIT_ENC_REQ];
      key_ok_r <= CP_CONTROL_RESET[BIT_KEY_OK];
      list_ok_r <= 1'b0;
      enc_off_r <= 1'b0;
      rst_r <= 1'b0;
      dis_r <= 1'b0;
      mode_r <= MODE_RESET;
      cmd_r <= '0;
      vsel_r <= VID_PLAIN;
      rdata_r <= 32'h0000_0000;
      ready_r <= 1'b0;
      err_r <= 1'b0;
      key_rdy_d_r <= 1'b0;
    end else begin
      auth_en_r <= auth_en_nxt;
      enc_req_r <= enc_req_nxt;
      key_ok_r <= key_ok_nxt;
      list_ok_r <= list_ok_nxt;
      enc_off_r <= enc_off_nxt;
      rst_r <= rst_nxt;
      dis_r <= dis_nxt;
      mode_r <= mode_nxt;
      cmd_r <= cmd_nxt;
      vsel_r <= vsel_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      err_r <= err_nxt;
      key_rdy_d_r <= auth_sts.receiver_key_ready;
    end
  end

  assign prdata = rdata_r;
  assign pready = ready_r;
  assign pslverr = err_r;
  assign auth_cmd = cmd_r;
  assign video_sel = vsel_r;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_selfclr;
    rst_r |=> !rst_r;
  endproperty
  rst_selfclear_a: assert property (p_selfclr)
    else $error("engine reset bit did not self-clear");
  reset_disables_a: assert property (
    wr_ctl && wb[BIT_ENGINE_RST] |=> !auth_en_r && cmd_r.engine_reset)
    else $error("engine reset did not disable authentication");
  list_selfclear_a: assert property (
    list_ok_r |=> !list_ok_r)
    else $error("list approval did not self-clear");
  key_clear_a: assert property (
    $rose(auth_sts.receiver_key_ready) |=> !key_ok_r)
    else $error("key approval not cleared on key ready");
  key_zero_a: assert property (
    wr_ctl && !wb[BIT_KEY_OK] && key_ok_r && !key_rdy_rise |=> key_ok_r)
    else $error("writing zero changed key approval");
  encoff_plain_a: assert property (
    enc_off_r |=> vsel_r == VID_PLAIN)
    else $error("encrypt-off did not force plain video");
  blue_screen_a: assert property (
    enc_req_rd && !enc_off_r && mode_r == MODE_REG &&
    !auth_sts.authenticated |=> vsel_r == VID_BLUE)
    else $error("blue screen not selected");
  encrypted_vid_a: assert property (
    enc_req_rd && !enc_off_r && mode_r == MODE_REG &&
    auth_sts.authenticated |=> vsel_r == VID_ENCRYPTED)
    else $error("encrypted video not selected");
  always_reads_a: assert property (
    rd_en && hit_ctl && mode_r == MODE_ALWAYS |=> prdata[BIT_ENC_REQ])
    else $error("encrypt request not read as one");
  restart_pulse_a: assert property (
    wr_ctl && wb[BIT_AUTH_EN] && !wb[BIT_AUTH_DIS] && !wb[BIT_ENGINE_RST]
    && auth_en_r |=> cmd_r.auth_restart ##1 !cmd_r.auth_restart)
    else $error("restart not pulsed");
  disable_auth_a: assert property (
    wr_ctl && wb[BIT_AUTH_DIS] |=> !auth_en_r ##1 !dis_r)
    else $error("auth disable failed");
  rsvd_zero_a: assert property (
    pready |-> !prdata[BIT_RSVD])
    else $error("reserved bit read nonzero");
  start_pulse_a: assert property (
    wr_ctl && wb[BIT_AUTH_EN] && !wb[BIT_AUTH_DIS] && !wb[BIT_ENGINE_RST]
    && !auth_en_r |=> auth_en_r && cmd_r.auth_start)
    else $error("enable did not start authentication");
  enable_zero_a: assert property (
    wr_ctl && !wb[BIT_AUTH_EN] && !wb[BIT_AUTH_DIS] && !wb[BIT_ENGINE_RST]
    |=> $stable(auth_en_r) && !cmd_r.auth_start && !cmd_r.auth_restart)
    else $error("writing zero to enable had an effect");
  restart_keeps_a: assert property (
    wr_ctl && wb[BIT_AUTH_EN] && !wb[BIT_AUTH_DIS] && !wb[BIT_ENGINE_RST]
    |=> auth_en_r)
    else $error("restart dropped authentication enable");
  enable_read_a: assert property (
    rd_en && hit_ctl |=> prdata[BIT_AUTH_EN] == $past(auth_en_r))
    else $error("enable bit did not read enabled status");
  key_approve_a: assert property (
    wr_ctl && wb[BIT_KEY_OK] && !key_rdy_rise |=> key_ok_r)
    else $error("key approval not held");
  key_cmd_a: assert property (
    wr_ctl && wb[BIT_KEY_OK] |=> cmd_r.key_approved)
    else $error("key approval not passed to engine");
  list_approve_a: assert property (
    wr_ctl && wb[BIT_LIST_OK] |=> cmd_r.list_approved && list_ok_r)
    else $error("list approval not passed to engine");
  encoff_clears_a: assert property (
    wr_ctl && wb[BIT_ENC_OFF] |=> enc_off_r && !enc_req_r)
    else $error("encrypt-off did not take effect");
  encoff_auth_a: assert property (
    wr_ctl && wb[BIT_ENC_OFF] && !wb[BIT_ENGINE_RST] && !wb[BIT_AUTH_DIS]
    && !wb[BIT_AUTH_EN] |=> $stable(auth_en_r) && !cmd_r.engine_reset
    && !cmd_r.auth_stop && !cmd_r.auth_restart)
    else $error("encrypt-off disturbed authentication");
  plain_video_a: assert property (
    !enc_req_rd |=> vsel_r == VID_PLAIN)
    else $error("plain video not selected");
  mode_write_a: assert property (
    wr_en && hit_cfg && pstrb[0] |=> mode_r == $past(pwdata[1:0]))
    else $error("encryption mode not written");
  always_video_a: assert property (
    mode_r == MODE_ALWAYS && !enc_off_r && auth_sts.authenticated
    |=> vsel_r == VID_ENCRYPTED)
    else $error("always mode did not encrypt");
  always_locked_a: assert property (
    wr_ctl && mode_r == MODE_ALWAYS && !wb[BIT_ENC_OFF]
    |=> $stable(enc_req_r))
    else $error("encrypt request written in always mode");
  engine_first_a: assert property (
    wr_ctl && wb[BIT_ENGINE_RST]
    |=> !cmd_r.auth_start && !cmd_r.auth_restart && !cmd_r.auth_stop)
    else $error("engine reset did not take priority");
  dis_first_a: assert property (
    wr_ctl && wb[BIT_AUTH_DIS] && !wb[BIT_ENGINE_RST]
    |=> cmd_r.auth_stop && !cmd_r.auth_start && !cmd_r.auth_restart)
    else $error("auth disable did not take priority");
  inband_video_a: assert property (
    mode_r == MODE_INBAND && !auth_sts.inband_encrypt
    |=> vsel_r == VID_PLAIN)
    else $error("in-band mode encrypted without request");
  enable_c: cover property (@(posedge pclk) wr_ctl && wb[BIT_AUTH_EN]);
  blue_c: cover property (@(posedge pclk) vsel_r == VID_BLUE);
  keyclr_c: cover property (@(posedge pclk) key_ok_r && key_rdy_rise);
  err_c: cover property (@(posedge pclk) pslverr);
  modereg_c: cover property (@(posedge pclk) mode_r == MODE_REG && vsel_r == VID_ENCRYPTED);
endmodule

/* File: cp_ctl_pkg.sv */
// Package: register map, field positions and types for content-protect control
package cp_ctl_pkg;
  localparam logic [7:0] CP_CONTROL_IDX = 8'hc3;
  localparam logic [11:0] CP_CONTROL_ADDR = {2'b00, CP_CONTROL_IDX, 2'b00};
  localparam logic [11:0] CP_CONFIG_ADDR = 12'h400;
  localparam logic [11:0] CP_STATUS_ADDR = 12'h404;
  localparam logic [7:0] CP_CONTROL_RESET = 8'h00;
  localparam int BIT_ENGINE_RST = 7;
  localparam int BIT_RSVD = 6;
  localparam int BIT_LIST_OK = 5;
  localparam int BIT_KEY_OK = 4;
  localparam int BIT_ENC_OFF = 3;
  localparam int BIT_ENC_REQ = 2;
  localparam int BIT_AUTH_DIS = 1;
  localparam int BIT_AUTH_EN = 0;
  localparam logic [1:0] MODE_AUTHED = 2'h0;
  localparam logic [1:0] MODE_REG = 2'h1;
  localparam logic [1:0] MODE_ALWAYS = 2'h2;
  localparam logic [1:0] MODE_INBAND = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h0;

  typedef enum logic [1:0] {
    VID_PLAIN = 2'b00,
    VID_ENCRYPTED = 2'b01,
    VID_BLUE = 2'b10
  } video_sel_t;

  // Requests toward the authentication engine, one-cycle pulses
  typedef struct packed {
    logic engine_reset;
    logic auth_start;
    logic auth_restart;
    logic auth_stop;
    logic key_approved;
    logic list_approved;
  } auth_cmd_t;

  // Status coming back from the authentication engine
  typedef struct packed {
    logic authenticated;
    logic receiver_key_ready;
    logic repeater_list_ready;
    logic repeater_mode;
    logic inband_encrypt;
  } auth_sts_t;
endpackage

/* File: cp_video_sel.sv */
// Video path selection from encryption request, mode and authentication
`timescale 1ns/1ps
module cp_video_sel
  import cp_ctl_pkg::*;
(
  // Controls
  input wire logic enc_req,
  input wire logic enc_off,
  input wire logic [1:0] enc_mode,
  input wire logic inband_encrypt,
  input wire logic authenticated,
  // Selection
  output video_sel_t sel
);
  logic want;

  always_comb begin
    case (enc_mode)
      MODE_ALWAYS: want = 1'b1;
      MODE_INBAND: want = enc_req & inband_encrypt;
      MODE_AUTHED: want = enc_req;
      default: want = enc_req;
    endcase
    if (!want || enc_off) begin
      sel = VID_PLAIN;
    end else if (authenticated) begin
      sel = VID_ENCRYPTED;
    end else begin
      sel = VID_BLUE;
    end
  end
endmodule

/* File: content_protect_tx_control_tb.sv */
// Testbench for the content-protect control register bank
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module content_protect_tx_control_tb
  import cp_ctl_pkg::*;
;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  auth_sts_t auth_sts = '0;
  auth_cmd_t auth_cmd;
  auth_cmd_t cmd;
  video_sel_t video_sel;
  int mismatches = 0;
  int total_checks = 0;
  localparam logic [11:0] CTL = CP_CONTROL_ADDR;

  always #4 pclk = ~pclk;

  cp_control_register dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .auth_sts(auth_sts), .auth_cmd(auth_cmd), .video_sel(video_sel)
  );

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One APB transfer; response captured while pready stands
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      mismatches++;
      stop_test();
    end else begin
      rd = prdata;
      err = pslverr;
      cmd = auth_cmd;
      @(posedge pclk);
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask

  task automatic rdreg(input logic [11:0] a);
    xfer(1'h0, a, 32'h0);
  endtask

  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    rdreg(CTL);
    `CHK(rd, 32'h0);
    `CHK(video_sel, VID_PLAIN);
    rdreg(12'h008);
    `CHK({err, rd}, {1'h1, 32'h0});
    $display("test reset done");
    wr(CTL, 32'h01);
    `CHK({cmd.auth_start, cmd.auth_restart}, 2'h2);
    rdreg(CTL);
    `CHK(rd[0], 1'h1);
    wr(CTL, 32'h01);
    `CHK({cmd.auth_start, cmd.auth_restart}, 2'h1);
    wr(CTL, 32'h00);
    `CHK(cmd, 6'h00);
    $display("test enable done");
    wr(CTL, 32'h04);
    settle();
    `CHK(video_sel, VID_BLUE);
    @(posedge pclk);
    auth_sts.authenticated <= 1'h1;
    settle();
    `CHK(video_sel, VID_ENCRYPTED);
    wr(CTL, 32'h08);
    `CHK(cmd, 6'h00);
    settle();
    `CHK(video_sel, VID_PLAIN);
    rdreg(CTL);
    `CHK(rd[3:0], 4'h1);
    $display("test encrypt done");
    wr(CP_CONFIG_ADDR, {30'h0, MODE_ALWAYS});
    wr(CTL, 32'h00);
    rdreg(CTL);
    `CHK(rd[2], 1'h1);
    settle();
    `CHK(video_sel, VID_ENCRYPTED);
    wr(CP_CONFIG_ADDR, {30'h0, MODE_REG});
    wr(CTL, 32'h04);
    settle();
    `CHK(video_sel, VID_ENCRYPTED);
    @(posedge pclk);
    auth_sts.authenticated <= 1'h0;
    settle();
    `CHK(video_sel, VID_BLUE);
    wr(CP_CONFIG_ADDR, {30'h0, MODE_INBAND});
    settle();
    `CHK(video_sel, VID_PLAIN);
    @(posedge pclk);
    auth_sts <= 5'h11;
    settle();
    `CHK(video_sel, VID_ENCRYPTED);
    @(posedge pclk);
    auth_sts <= 5'h10;
    wr(CP_CONFIG_ADDR, {30'h0, MODE_AUTHED});
    $display("test always done");
    wr(CTL, 32'h02);
    `CHK(cmd.auth_stop, 1'h1);
    rdreg(CTL);
    `CHK(rd[1:0], 2'h0);
    wr(CTL, 32'h01);
    wr(CTL, 32'h80);
    `CHK(cmd.engine_reset, 1'h1);
    rdreg(CTL);
    `CHK({rd[7], rd[0]}, 2'h0);
    $display("test reset bits done");
    wr(CTL, 32'h10);
    `CHK(cmd.key_approved, 1'h1);
    wr(CTL, 32'h00);
    rdreg(CTL);
    `CHK(rd[4], 1'h1);
    @(posedge pclk);
    auth_sts.receiver_key_ready <= 1'h1;
    settle();
    rdreg(CTL);
    `CHK(rd[4], 1'h0);
    @(posedge pclk);
    auth_sts.repeater_list_ready <= 1'h1;
    wr(CTL, 32'h60);
    `CHK(cmd.list_approved, 1'h1);
    rdreg(CTL);
    `CHK(rd[6:5], 2'h0);
    rdreg(CP_STATUS_ADDR);
    `CHK(rd[4:0], 5'h1c);
    @(posedge pclk);
    pstrb <= 4'he;
    wr(CTL, 32'h01);
    `CHK(cmd, 6'h00);
    rdreg(CTL);
    `CHK(rd[0], 1'h0);
    $display("test approvals done");
    stop_test();
  end
endmodule
